// ### rtl/srgw_params.svh
// Constants of the sample record group writer: offsets, field positions,
// reset values and word counts. Assumes a 32-bit classic Wishbone slave port.
// Functional notes
// - First memory word holds canonical data linear address.
// - Unknown address is written as zero.
// - Source code in bits 3:0, zero unknown.
// - Bit 4 flags second-level translation miss.
// - Bit 5 flags locked atomic access.
// - Bit 6 flags store-forward data block.
// - Bit 7 flags store address-conflict block.
// - Instruction latency, dispatch to completion, bits 15:0.
// - Load cache latency in bits 47:32.
// - Store cache latency, L1 write to line done.
// - Cache latency excludes ordering and translation time.
// - Region cycles 31:0, abort details 63:32.
// - General registers only when selected, 64 bits each.
// - Outside 64-bit mode zero upper and extended registers.
// - Order: flags, pointer, eight legacy, then extended.
// - Capture committed state just after trigger completes.
// - Sixteen vector registers, zero when extension disabled.
// - Outside 64-bit mode vector 8-15 are zero.
// - History entries only when selected, count configured.
// - Entry is source, target, then auxiliary word.
// - Entries from top index downward, modulo depth.
// - Groups packed; byte size in first word 63:48.
// - Count field holds entries minus one.
`ifndef SRGW_PARAMS_SVH
`define SRGW_PARAMS_SVH

// Register byte offsets.
`define SRGW_REG_SELECT 4'h0
`define SRGW_REG_STATUS 4'h4

// Group-select field positions and reset value.
`define SRGW_SEL_MEM 0
`define SRGW_SEL_GPR 1
`define SRGW_SEL_VEC 2
`define SRGW_SEL_BR 3
`define SRGW_SEL_CNT_LO 24
`define SRGW_SEL_CNT_HI 31
`define SRGW_SELECT_RST 32'h0000_0000

// Word counts per group and bytes per word.
`define SRGW_HDR_WORDS 9'h001
`define SRGW_MEM_WORDS 9'h004
`define SRGW_GPR_WORDS 9'h012
`define SRGW_VEC_WORDS 9'h020
`define SRGW_BR_PARTS 2'h3
`define SRGW_WORD_BYTES 16'h0008

// Width of the latency saturating counters.
`define SRGW_LAT_W 16
`define SRGW_TXN_W 32

`endif

// ### rtl/srgw_pkg.sv
// Types shared by the sample record group writer.
// Assumes the constants header is included by users that need field positions.
package srgw_pkg;

    // Group the cursor currently emits.
    typedef enum logic [2:0] {
        G_IDLE,
        G_HDR,
        G_MEM,
        G_GPR,
        G_VEC,
        G_BR
    } srgw_grp_t;

    // Committed core state presented with a sample request.
    typedef struct packed {
        logic mode64;
        logic vec_en;
        logic [63:0] flags;
        logic [63:0] next_ip;
        logic [15:0][63:0] general_register_group;
        logic [15:0][127:0] vec;
    } srgw_core_t;

    // Memory access details of the sampled instruction.
    typedef struct packed {
        logic addr_valid;
        logic [63:0] data_linear_address;
        logic [3:0] data_source;
        logic second_level_translation_miss;
        logic locked_access_flag;
        logic data_block;
        logic address_block;
        logic [31:0] abort_info;
    } srgw_mem_t;

    // One branch history entry.
    typedef struct packed {
        logic [63:0] source;
        logic [63:0] target;
        logic [63:0] aux;
    } srgw_branch_history_entry_t;

endpackage

// ### rtl/srgw_writer.sv
// Sample record group writer: builds the optional groups of a precise sample
// record and streams them as 64-bit words. Assumes core-side inputs share
// i_core_clk, and that the history array holds steady while o_busy is high.
`timescale 1ns/100ps
`include "srgw_params.svh"

module srgw_writer #(
    parameter int HIST_ENTRIES = 32,
    parameter int HIST_W = 5
) (
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Wishbone slave.
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [3:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // Latency events from the core.
    input wire logic i_load_dispatch,
    input wire logic i_inst_complete,
    input wire logic i_cache_start,
    input wire logic i_cache_done,
    input wire logic i_cache_other,
    input wire logic i_txn_active,
    // Sample trigger with committed state.
    input wire logic i_sample_req,
    input wire srgw_pkg::srgw_core_t i_core,
    input wire srgw_pkg::srgw_mem_t i_mem,
    input wire logic [HIST_W-1:0] i_history_top_index,
    input wire logic [HIST_ENTRIES-1:0][191:0] i_hist,
    // Record stream.
    output logic o_rec_valid,
    output logic [63:0] o_rec_word,
    output logic o_rec_last,
    input wire logic i_rec_ready,
    output logic o_busy
);

    // Refuse history depths the index cannot reach, at elaboration.
    if (HIST_ENTRIES < 1 || HIST_ENTRIES > (1 << HIST_W) || HIST_W > 8) begin : g_bad_depth
        $error("srgw_writer: bad history depth or index width");
    end

    localparam logic [HIST_W-1:0] HIST_LAST = HIST_W'(HIST_ENTRIES - 1);

    // Saturating increment used by all latency counters.
    function automatic logic [31:0] sat_inc(input logic [31:0] v, input logic [31:0] max);
        sat_inc = (v == max) ? v : v + 32'h0000_0001;
    endfunction

    // Group following g among those selected.
    function automatic srgw_pkg::srgw_grp_t next_grp(input srgw_pkg::srgw_grp_t g, input logic [3:0] s);
        next_grp = srgw_pkg::G_IDLE;
        if (g == srgw_pkg::G_HDR && s[`SRGW_SEL_MEM]) next_grp = srgw_pkg::G_MEM;
        else if (g <= srgw_pkg::G_MEM && s[`SRGW_SEL_GPR]) next_grp = srgw_pkg::G_GPR;
        else if (g <= srgw_pkg::G_GPR && s[`SRGW_SEL_VEC]) next_grp = srgw_pkg::G_VEC;
        else if (g <= srgw_pkg::G_VEC && s[`SRGW_SEL_BR]) next_grp = srgw_pkg::G_BR;
    endfunction

    // Registers.
    logic [31:0] select_ff;
    logic [15:0] size_ff;
    logic [31:0] o_wb_dat_ff;
    logic o_wb_ack_ff;
    logic [`SRGW_LAT_W-1:0] inst_cnt_ff;
    logic inst_run_ff;
    logic [`SRGW_LAT_W-1:0] inst_lat_ff;
    logic [`SRGW_LAT_W-1:0] cache_cnt_ff;
    logic cache_run_ff;
    logic [`SRGW_LAT_W-1:0] cache_lat_ff;
    logic [`SRGW_TXN_W-1:0] txn_cnt_ff;
    logic txn_was_ff;
    logic [`SRGW_TXN_W-1:0] txn_lat_ff;
    srgw_pkg::srgw_core_t core_ff;
    srgw_pkg::srgw_mem_t mem_ff;
    logic [`SRGW_LAT_W-1:0] snap_inst_ff;
    logic [`SRGW_LAT_W-1:0] snap_cache_ff;
    logic [`SRGW_TXN_W-1:0] snap_txn_ff;
    logic [31:0] rec_sel_ff;
    srgw_pkg::srgw_grp_t grp_ff;
    logic [8:0] idx_ff;
    logic [7:0] ent_ff;
    logic [HIST_W-1:0] ptr_ff;
    logic o_rec_valid_ff;
    logic [63:0] o_rec_word_ff;
    logic o_rec_last_ff;

    // Bus decode: one-cycle ack, unmapped reads return zero, writes ignored.
    wire bus_req = i_wb_cyc && i_wb_stb && !o_wb_ack_ff;
    wire hit_sel = (i_wb_adr == `SRGW_REG_SELECT);
    wire hit_stat = (i_wb_adr == `SRGW_REG_STATUS);
    wire [31:0] sel_mask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
    wire [31:0] nxt_select = (select_ff & ~sel_mask) | (i_wb_dat & sel_mask);
    wire [31:0] rd_data = hit_sel ? select_ff : hit_stat ? {size_ff, 15'h0000, o_busy} : 32'h0000_0000;

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            select_ff <= `SRGW_SELECT_RST;
            o_wb_ack_ff <= 1'b0;
            o_wb_dat_ff <= 32'h0000_0000;
        end else begin
            o_wb_ack_ff <= bus_req;
            o_wb_dat_ff <= bus_req ? rd_data : 32'h0000_0000;
            if (bus_req && i_wb_we && hit_sel) begin
                select_ff <= nxt_select;
            end
        end
    end

    // Instruction latency: dispatch of the load to completion of its instruction.
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            inst_run_ff <= 1'b0;
            inst_cnt_ff <= 16'h0000;
            inst_lat_ff <= 16'h0000;
        end else if (i_load_dispatch) begin
            inst_run_ff <= 1'b1;
            inst_cnt_ff <= 16'h0001;
        end else if (inst_run_ff) begin
            if (i_inst_complete) begin
                inst_run_ff <= 1'b0;
                inst_lat_ff <= inst_cnt_ff;
            end else begin
                inst_cnt_ff <= 16'(sat_inc({16'h0000, inst_cnt_ff}, 32'h0000_FFFF));
            end
        end
    end

    // Cache latency: load cache access or store L1 write until data or line done.
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            cache_run_ff <= 1'b0;
            cache_cnt_ff <= 16'h0000;
            cache_lat_ff <= 16'h0000;
        end else if (i_cache_start) begin
            cache_run_ff <= 1'b1;
            cache_cnt_ff <= 16'h0001;
        end else if (cache_run_ff) begin
            if (i_cache_done) begin
                cache_run_ff <= 1'b0;
                cache_lat_ff <= cache_cnt_ff;
            end else if (!i_cache_other) begin
                cache_cnt_ff <= 16'(sat_inc({16'h0000, cache_cnt_ff}, 32'h0000_FFFF));
            end
        end
    end

    // Transactional region cycles, latched when the region ends either way.
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            txn_was_ff <= 1'b0;
            txn_cnt_ff <= 32'h0000_0000;
            txn_lat_ff <= 32'h0000_0000;
        end else begin
            txn_was_ff <= i_txn_active;
            if (i_txn_active && !txn_was_ff) begin
                txn_cnt_ff <= 32'h0000_0001;
            end else if (i_txn_active) begin
                txn_cnt_ff <= sat_inc(txn_cnt_ff, 32'hFFFF_FFFF);
            end else if (txn_was_ff) begin
                txn_lat_ff <= txn_cnt_ff;
            end
        end
    end

    // Record length in bytes for the selected groups.
    wire [7:0] cnt_field = select_ff[`SRGW_SEL_CNT_HI:`SRGW_SEL_CNT_LO];
    wire [15:0] br_bytes = 16'(({8'h00, cnt_field} + 16'h0001) * 16'h0018);
    wire [15:0] nxt_size = 16'(`SRGW_WORD_BYTES * 16'(`SRGW_HDR_WORDS)
        + (select_ff[`SRGW_SEL_MEM] ? `SRGW_WORD_BYTES * 16'(`SRGW_MEM_WORDS) : 16'h0000)
        + (select_ff[`SRGW_SEL_GPR] ? `SRGW_WORD_BYTES * 16'(`SRGW_GPR_WORDS) : 16'h0000)
        + (select_ff[`SRGW_SEL_VEC] ? `SRGW_WORD_BYTES * 16'(`SRGW_VEC_WORDS) : 16'h0000)
        + (select_ff[`SRGW_SEL_BR] ? br_bytes : 16'h0000));

    // Cursor stepping over the selected groups with no gaps.
    wire start = (grp_ff == srgw_pkg::G_IDLE) && i_sample_req;
    wire advance = o_rec_valid_ff && i_rec_ready;
    wire [8:0] grp_len = (grp_ff == srgw_pkg::G_MEM) ? `SRGW_MEM_WORDS :
        (grp_ff == srgw_pkg::G_GPR) ? `SRGW_GPR_WORDS :
        (grp_ff == srgw_pkg::G_VEC) ? `SRGW_VEC_WORDS : `SRGW_HDR_WORDS;
    wire br_part_end = (idx_ff[1:0] == `SRGW_BR_PARTS - 2'h1);
    wire br_ent_end = (ent_ff == rec_sel_ff[`SRGW_SEL_CNT_HI:`SRGW_SEL_CNT_LO]);
    wire in_br = (grp_ff == srgw_pkg::G_BR);
    wire grp_end = in_br ? (br_part_end && br_ent_end) : (idx_ff == grp_len - 9'h001);
    wire srgw_pkg::srgw_grp_t nxt_grp = grp_end ? next_grp(grp_ff, rec_sel_ff[3:0]) : grp_ff;
    wire [8:0] nxt_idx = grp_end ? 9'h000 : (in_br && br_part_end) ? 9'h000 : idx_ff + 9'h001;
    wire [7:0] nxt_ent = (grp_end || !in_br) ? 8'h00 : br_part_end ? ent_ff + 8'h01 : ent_ff;
    wire [HIST_W-1:0] ptr_dec = (ptr_ff == {HIST_W{1'b0}}) ? HIST_LAST : ptr_ff - HIST_W'(1);
    wire [HIST_W-1:0] nxt_ptr = (in_br && br_part_end) ? ptr_dec : ptr_ff;
    wire nxt_last = (nxt_grp != srgw_pkg::G_IDLE) && (next_grp(nxt_grp, rec_sel_ff[3:0]) == srgw_pkg::G_IDLE)
        && (nxt_grp == srgw_pkg::G_BR ? (nxt_ent == rec_sel_ff[`SRGW_SEL_CNT_HI:`SRGW_SEL_CNT_LO]
        && nxt_idx[1:0] == `SRGW_BR_PARTS - 2'h1) : nxt_idx == (nxt_grp == srgw_pkg::G_MEM ? `SRGW_MEM_WORDS
        : nxt_grp == srgw_pkg::G_GPR ? `SRGW_GPR_WORDS : `SRGW_VEC_WORDS) - 9'h001);

    // Memory group words.
    wire [63:0] mem_w0 = mem_ff.addr_valid ? mem_ff.data_linear_address : 64'h0;
    wire [63:0] mem_w1 = {56'h0, mem_ff.address_block, mem_ff.data_block,
        mem_ff.locked_access_flag, mem_ff.second_level_translation_miss,
        mem_ff.data_source};
    wire [63:0] mem_w2 = {16'h0000, snap_cache_ff, 16'h0000, snap_inst_ff};
    wire [63:0] mem_w3 = {mem_ff.abort_info, snap_txn_ff};

    // General register words: flags, next pointer, then registers 0..15.
    wire [4:0] gpr_i = 5'(nxt_idx - 9'h002);
    wire [63:0] gpr_raw = core_ff.general_register_group[gpr_i[3:0]];
    wire [63:0] gpr_word = core_ff.mode64 ? gpr_raw : gpr_i[3] ? 64'h0 : {32'h0, gpr_raw[31:0]};
    wire [63:0] gpr_w = (nxt_idx == 9'h000) ? core_ff.flags : (nxt_idx == 9'h001) ? core_ff.next_ip
        : gpr_word;

    // Vector words: low half then high half of each register.
    wire [127:0] vec_raw = core_ff.vec[nxt_idx[4:1]];
    wire vec_zero = !core_ff.vec_en || (!core_ff.mode64 && nxt_idx[4]);
    wire [63:0] vec_w = vec_zero ? 64'h0 : nxt_idx[0] ? vec_raw[127:64] : vec_raw[63:0];

    // History words: source, target, auxiliary.
    wire [191:0] hist_ent = i_hist[nxt_ptr];
    wire [63:0] br_w = (nxt_idx[1:0] == 2'h0) ? hist_ent[191:128] :
        (nxt_idx[1:0] == 2'h1) ? hist_ent[127:64] : hist_ent[63:0];

    // Word selected for the cursor after this step.
    wire [63:0] nxt_word = (nxt_grp == srgw_pkg::G_MEM) ? (nxt_idx[1:0] == 2'h0 ? mem_w0 :
        nxt_idx[1:0] == 2'h1 ? mem_w1 : nxt_idx[1:0] == 2'h2 ? mem_w2 : mem_w3) :
        (nxt_grp == srgw_pkg::G_GPR) ? gpr_w : (nxt_grp == srgw_pkg::G_VEC) ? vec_w :
        (nxt_grp == srgw_pkg::G_BR) ? br_w : 64'h0;

    // Snapshot of committed state taken with the trigger.
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            core_ff <= '0;
            mem_ff <= '0;
            snap_inst_ff <= 16'h0000;
            snap_cache_ff <= 16'h0000;
            snap_txn_ff <= 32'h0000_0000;
            rec_sel_ff <= 32'h0000_0000;
            size_ff <= 16'h0000;
        end else if (start) begin
            core_ff <= i_core;
            mem_ff <= i_mem;
            snap_inst_ff <= inst_lat_ff;
            snap_cache_ff <= cache_lat_ff;
            snap_txn_ff <= txn_lat_ff;
            rec_sel_ff <= select_ff;
            size_ff <= nxt_size;
        end
    end

    // Stream sequencer: header first, then each selected group in turn.
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            grp_ff <= srgw_pkg::G_IDLE;
            idx_ff <= 9'h000;
            ent_ff <= 8'h00;
            ptr_ff <= {HIST_W{1'b0}};
            o_rec_valid_ff <= 1'b0;
            o_rec_word_ff <= 64'h0;
            o_rec_last_ff <= 1'b0;
        end else if (start) begin
            grp_ff <= srgw_pkg::G_HDR;
            idx_ff <= 9'h000;
            ent_ff <= 8'h00;
            ptr_ff <= i_history_top_index;
            o_rec_valid_ff <= 1'b1;
            o_rec_word_ff <= {nxt_size, 16'h0000, select_ff};
            o_rec_last_ff <= (select_ff[3:0] == 4'h0);
        end else if (advance) begin
            grp_ff <= nxt_grp;
            idx_ff <= nxt_idx;
            ent_ff <= nxt_ent;
            ptr_ff <= nxt_ptr;
            o_rec_valid_ff <= (nxt_grp != srgw_pkg::G_IDLE);
            o_rec_word_ff <= nxt_word;
            o_rec_last_ff <= nxt_last;
        end
    end

    // Outputs straight from flops, except o_busy, which is decoded from grp_ff.
    assign o_wb_dat = o_wb_dat_ff;
    assign o_wb_ack = o_wb_ack_ff;
    assign o_rec_valid = o_rec_valid_ff;
    assign o_rec_word = o_rec_word_ff;
    assign o_rec_last = o_rec_last_ff;
    assign o_busy = (grp_ff != srgw_pkg::G_IDLE);

endmodule

// ### sim/srgw_snk.sv
// Memory buffer model that accepts record words with random stalls.
// Assumes the writer's valid, word and last outputs share the core clock.
`timescale 1ns/100ps
module srgw_snk (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Record stream.
    input wire logic i_valid,
    input wire logic [63:0] i_word,
    input wire logic i_last,
    output logic o_ready = 1'b0
);
    logic [63:0] q[$];
    int last_at = -1;
    logic [31:0] s = 32'h0000_0007;

    // Store every accepted word and stall about one cycle in four.
    always @(posedge i_clk) begin
        if (i_valid && o_ready) begin
            if (i_last) last_at = q.size();
            q.push_back(i_word);
        end
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        o_ready <= i_rst_n && (s[1:0] != 2'b00);
    end
endmodule

// ### sim/srgw_writer_asserts.sv
// Port checker for the sample record group writer.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/100ps
module srgw_chk (
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Register bus.
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic o_wb_ack,
    // Sample and record stream.
    input wire logic i_sample_req,
    input wire logic o_rec_valid,
    input wire logic [63:0] o_rec_word,
    input wire logic o_rec_last,
    input wire logic i_rec_ready,
    input wire logic o_busy
);
    logic [8:0] idx_ff;
    logic mem_ff;
    logic take;
    logic [15:0] exp_size;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    // Size the header must carry, worked out from its own select bits.
    assign take = o_rec_valid && i_rec_ready;
    assign exp_size = 16'h0008 + (o_rec_word[0] ? 16'h0020 : 16'h0000) + (o_rec_word[1] ? 16'h0090 : 16'h0000)
        + (o_rec_word[2] ? 16'h0100 : 16'h0000) + (o_rec_word[3] ? 16'h0018 * ({8'h00, o_rec_word[31:24]} + 16'h0001) : 16'h0000);

    // Word index in the record and whether the memory group is present.
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            idx_ff <= 9'h000;
            mem_ff <= 1'b0;
        end else if (take) begin
            idx_ff <= o_rec_last ? 9'h000 : idx_ff + 9'h001;
            if (idx_ff == 9'h000) mem_ff <= o_rec_word[0];
        end
    end

    ack_one_cycle_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack longer than one cycle");
    ack_follows_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("ack missing");
    word_held_a: assert property (o_rec_valid && !i_rec_ready |=> o_rec_valid && $stable(o_rec_word)
        && $stable(o_rec_last)) else $error("word changed while stalled");
    header_next_a: assert property (i_sample_req && !o_busy |=> o_rec_valid && idx_ff == 9'h000)
        else $error("header late");
    busy_covers_a: assert property (o_rec_valid |-> o_busy) else $error("valid without busy");
    stream_stops_a: assert property (take && o_rec_last |=> !o_rec_valid) else $error("word after last");
    busy_drop_a: assert property ($fell(o_busy) |-> $past(take) && $past(o_rec_last)) else $error("busy fell early");
    header_size_a: assert property (o_rec_valid && idx_ff == 9'h000 |-> o_rec_word[63:48] == exp_size
        && o_rec_word[47:32] == 16'h0000) else $error("header size wrong");
    info_pad_a: assert property (o_rec_valid && mem_ff && idx_ff == 9'h002 |-> o_rec_word[63:8] == 56'h0)
        else $error("access info pad set");
    latency_pad_a: assert property (o_rec_valid && mem_ff && idx_ff == 9'h003 |-> o_rec_word[63:48] == 16'h0000
        && o_rec_word[31:16] == 16'h0000) else $error("latency pad set");

    // Main scenarios.
    last_seen_c: cover property (take && o_rec_last);
    stall_seen_c: cover property (o_rec_valid && !i_rec_ready);
    refused_c: cover property (i_sample_req && o_busy);
endmodule
bind srgw_writer srgw_chk i_chk (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack), .i_sample_req(i_sample_req), .o_rec_valid(o_rec_valid),
    .o_rec_word(o_rec_word), .o_rec_last(o_rec_last), .i_rec_ready(i_rec_ready), .o_busy(o_busy));

// ### sim/srgw_writer_test.sv
// Self-checking bench for the sample record group writer.
// Assumes the sink model and the bound checker are compiled alongside.
`timescale 1ns/100ps
module srgw_writer_test;
    logic clk, rst_n, cyc, stb, we, ack, disp, comp, cst, cdn, oth, txn, req, rv, rl, rr, busy;
    logic [3:0] adr, bsel;
    logic [31:0] wdat, rdat, got, x, t, selv;
    logic [63:0] rw, w;
    logic [2:0] top;
    logic [7:0][191:0] hist;
    srgw_pkg::srgw_core_t core;
    srgw_pkg::srgw_mem_t mem;
    logic [63:0] eq[$];
    int bad_count, checks_done, n, p;

    srgw_writer #(.HIST_ENTRIES(8), .HIST_W(3)) i_srgw_writer (.i_core_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(bsel), .i_wb_dat(wdat), .o_wb_dat(rdat),
        .o_wb_ack(ack), .i_load_dispatch(disp), .i_inst_complete(comp), .i_cache_start(cst), .i_cache_done(cdn),
        .i_cache_other(oth), .i_txn_active(txn), .i_sample_req(req), .i_core(core), .i_mem(mem),
        .i_history_top_index(top), .i_hist(hist), .o_rec_valid(rv), .o_rec_word(rw), .o_rec_last(rl),
        .i_rec_ready(rr), .o_busy(busy));
    srgw_snk i_srgw_snk (.i_clk(clk), .i_rst_n(rst_n), .i_valid(rv), .i_word(rw), .i_last(rl), .o_ready(rr));

    // Clock of 50 ns, and a watchdog far beyond the expected run.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (30000) @(posedge clk);
        bad_count++;
        stop_test;
    end

    function logic [31:0] rnd;
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction

    // Measured latencies may include or exclude the start cycle.
    function logic near(input logic [31:0] a, input logic [31:0] b);
        return a == b || a == b + 32'h1 || a + 32'h1 == b;
    endfunction

    task check(input logic [63:0] s, input logic [63:0] e);
        checks_done++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    task stop_test;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // One classic Wishbone cycle; read data lands in got.
    task wb(input logic w_en, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, bsel, wdat} <= {2'b11, w_en, a, s, d};
        @(posedge clk iff ack === 1'b1);
        got = rdat;
        {cyc, stb} <= 2'b00;
    endtask

    // Expected record; header size is the packed word count times eight.
    task build;
        logic [127:0] v;
        logic [191:0] h;
        eq = {64'h0};
        if (selv[0]) begin
            eq.push_back(mem.addr_valid ? mem.data_linear_address : 64'h0);
            eq.push_back({56'h0, mem.address_block, mem.data_block, mem.locked_access_flag,
                mem.second_level_translation_miss, mem.data_source});
            eq.push_back(64'h0);
            eq.push_back(64'h0);
        end
        if (selv[1]) begin
            eq.push_back(core.flags);
            eq.push_back(core.next_ip);
            for (int k = 0; k < 16; k++) eq.push_back(core.mode64 ? core.general_register_group[k] : (k < 8 ? {32'h0, core.general_register_group[k][31:0]} : 64'h0));
        end
        for (int k = 0; selv[2] && k < 16; k++) begin
            v = (core.vec_en && (core.mode64 || k < 8)) ? core.vec[k] : 128'h0;
            eq.push_back(v[63:0]);
            eq.push_back(v[127:64]);
        end
        for (int e = 0; selv[3] && e <= int'(selv[31:24]); e++) begin
            h = hist[top - 3'(e)];
            eq.push_back(h[191:128]);
            eq.push_back(h[127:64]);
            eq.push_back(h[63:0]);
        end
        eq[0] = {16'(eq.size() * 8), 16'h0000, selv};
    endtask

    initial begin
        x = 32'h0000_0013;
        rst_n = 1'b0;
        {cyc, stb, we, disp, comp, cst, cdn, oth, txn, req, adr, bsel, wdat, top} = '0;
        core = '0;
        mem = '0;
        hist = '0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        wb(1'b0, 4'h0, 4'hF, 32'h0);
        check(got, 32'h0);
        for (int it = 0; it < 6; it++) begin
            t = rnd();
            n = 3 + int'(t[4:0]);
            p = int'(t[9:5]) % (n - 1);
            // Latency events; the cache count pauses while oth is high.
            for (int c = 0; c <= n + 1; c++) begin
                @(posedge clk);
                {disp, cst, comp, cdn} <= {{2{c == 0}}, {2{c == n}}};
                oth <= c >= 1 && c <= p;
                txn <= c < n;
            end
            // Fresh sample state, with fixed corner selections first.
            t = rnd();
            selv = it == 0 ? 32'h0B00_000F : it == 1 ? 32'h0000_0001 : it == 2 ? 32'h0000_0006 : {4'h0, t[27:0]};
            mem <= 105'({rnd(), rnd(), rnd(), rnd()});
            mem.addr_valid <= it != 1 && t[31];
            top <= 3'(rnd());
            {core.flags, core.next_ip} <= {rnd(), rnd(), rnd(), rnd()};
            {core.mode64, core.vec_en} <= {it != 0 && t[29], it != 2 && t[30]};
            for (int k = 0; k < 16; k++) {core.general_register_group[k], core.vec[k]} <= {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
            for (int k = 0; k < 8; k++) hist[k] <= {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
            wb(1'b1, 4'h0, 4'hF, selv);
            wb(1'b1, 4'h0, 4'h0, ~selv);
            wb(1'b0, 4'h0, 4'hF, 32'h0);
            check(got, selv);
            build;
            i_srgw_snk.q.delete();
            i_srgw_snk.last_at = -1;
            @(posedge clk);
            req <= 1'b1;
            @(posedge clk);
            req <= 1'b0;
            @(posedge clk);
            req <= selv[1];
            @(posedge clk);
            req <= 1'b0;
            @(posedge clk iff busy === 1'b0);
            check(i_srgw_snk.q.size(), eq.size());
            check(i_srgw_snk.last_at, eq.size() - 1);
            for (int i = 0; i < eq.size(); i++) begin
                w = i_srgw_snk.q[i];
                if (selv[0] && i == 3) begin
                    check({w[63:48], w[31:16]}, 32'h0);
                    check(near({16'h0, w[15:0]}, n), 1'b1);
                    check(near({16'h0, w[47:32]}, n - p), 1'b1);
                end else if (selv[0] && i == 4) begin
                    check(w[63:32], mem.abort_info);
                    check(near(w[31:0], n), 1'b1);
                end else begin
                    check(w, eq[i]);
                end
            end
            wb(1'b0, 4'h4, 4'hF, 32'h0);
            check(got, {eq[0][63:48], 16'h0000});
        end
        wb(1'b1, 4'h8, 4'hF, 32'hFFFF_FFFF);
        wb(1'b0, 4'h8, 4'hF, 32'h0);
        check(got, 32'h0);
        stop_test;
    end
endmodule
